// File: verilog/power_unit_flags.sv
`timescale 1ns/1ps

// Behaviour
// - Flag bit 2: battery wake enable/flag.
// - Flag bit 0: pulse counter wake enable/flag.
// - Refuse oscillator off, suspend, sleep while flagged.
// - Flags read zero two clocks after suspend.
// - Mode bit 7 drives clock out pin.
// - Mode bit 6 enables wake request pin.
// - Mode bit 5 disables supply monitor.
// - Mode bits 4:0 read zero, ignore writes.
// - Control bits 7:3 are general flags.
// - Control bit 2 selects supply source.
// - Control bit 1 write enters stop.
// - Control bit 0 write enters idle.
// - Flags set on events regardless of enable.
// - Sleep exit drives wake request low.
module power_unit_flags
	import power_unit_pkg::*;
(
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire power_unit_pkg::sfr_req_t SFR_REQ,
	output logic [7:0]                  SFR_RDATA,
	input  wire logic                   BATT_MON_EVENT,
	input  wire logic                   PULSE_COUNT_EVENT,
	input  wire logic                   FLAG_CLEAR,
	input  wire logic                   SUSPEND_WAKE,
	input  wire logic                   SLEEP_EXIT,
	input  wire logic                   SUSPEND_REQ,
	input  wire logic                   SLEEP_REQ,
	input  wire logic                   LPOSC_OFF_REQ,
	output logic                        SUSPEND_GO,
	output logic                        SLEEP_GO,
	output logic                        LPOSC_OFF_GO,
	output logic                        BATT_WAKE_EN,
	output logic                        PULSE_WAKE_EN,
	input  wire logic                   RTC_OSC,
	output logic                        RTC_PIN_O,
	output logic                        RTC_PIN_OE_N,
	output logic                        WAKE_PIN_O,
	output logic                        WAKE_PIN_OE_N,
	output logic                        MONITOR_DISABLE,
	output logic                        SUPPLY_SELECT,
	output logic                        STOP_PULSE,
	output logic                        IDLE_PULSE
);
	import power_unit_pkg::*;

	localparam int PW = $clog2(WAKE_PULSE_CYC + 1);
	localparam int BW = $clog2(FLAG_BLANK_CYC + 1);
	localparam logic [PW-1:0] PULSE_LOAD = PW'(WAKE_PULSE_CYC);
	localparam logic [BW-1:0] BLANK_LOAD = BW'(FLAG_BLANK_CYC);

	typedef struct packed {
		wake_pair_t    enable;
		wake_pair_t    flags;
		logic [BW-1:0] blank;
		logic          clk_out_en;
		logic          wake_out_en;
		logic          mon_dis;
		logic [4:0]    gflags;
		logic          supply;
		logic          stop;
		logic          idle;
		logic          susp_go;
		logic          sleep_go;
		logic          osc_go;
		logic [PW-1:0] wake_cnt;
		logic          rtc_o;
		logic          rtc_oe_n;
		logic          wake_o;
		logic          wake_oe_n;
		logic [7:0]    rdata;
	} state_t;

	state_t     st_r;
	state_t     st_nxt;
	logic [2:0] sync_q;
	wake_pair_t evt;
	logic       rtc_s;
	wake_pair_t vis_flags;

	// Events and the oscillator come from other domains.
	level_sync #(
		.WIDTH(3)
	) u_sync (
		.CLK(CLK),
		.RST(RST),
		.D  ({RTC_OSC, BATT_MON_EVENT, PULSE_COUNT_EVENT}),
		.Q  (sync_q)
	);

	assign rtc_s     = sync_q[2];
	assign evt.batt  = sync_q[1];
	assign evt.pulse = sync_q[0];

	// Address decode used by both the write and the read path.
	function automatic logic hit(input sfr_req_t r, input logic [7:0] a, input logic chk_pg,
			input logic [3:0] pg);
		hit = (r.addr == a) && (!chk_pg || (r.page == pg));
	endfunction : hit

	// Flags are hidden, not lost, while the post-suspend blanking runs.
	// blank visible flags
	assign vis_flags = (st_r.blank != '0) ? '0 : st_r.flags;

	// Next-state logic for every register of the block.
	always_comb begin
		logic wr_flag;
		logic wr_mode;
		logic wr_power_control;
		logic any_flag;
		wr_flag  = SFR_REQ.wr && hit(SFR_REQ, ADDR_WAKE_MODE, 1'b1, PAGE_WAKE_FLAG);
		wr_mode  = SFR_REQ.wr && hit(SFR_REQ, ADDR_WAKE_MODE, 1'b1, PAGE_MODE);
		wr_power_control  = SFR_REQ.wr && hit(SFR_REQ, ADDR_POWER_CONTROL, 1'b0, 4'h0);
		any_flag = st_r.flags.batt || st_r.flags.pulse;
		st_nxt   = st_r;

		if (wr_flag) begin
			st_nxt.enable.batt  = SFR_REQ.wdata[BIT_BATT_WAKE];
			st_nxt.enable.pulse = SFR_REQ.wdata[BIT_PULSE_WAKE];
		end

		// Set beats clear so an event during the clear is kept.
		// flags track events always
		if (FLAG_CLEAR) begin
			st_nxt.flags = '0;
		end
		if (evt.batt) begin
			st_nxt.flags.batt = 1'b1;
		end
		if (evt.pulse) begin
			st_nxt.flags.pulse = 1'b1;
		end

		if (SUSPEND_WAKE) begin
			st_nxt.blank = BLANK_LOAD;
		end else if (st_r.blank != '0) begin
			st_nxt.blank = st_r.blank - 1'b1;
		end

		if (wr_mode) begin
			st_nxt.clk_out_en  = SFR_REQ.wdata[BIT_CLK_OUT_EN];
			st_nxt.wake_out_en = SFR_REQ.wdata[BIT_WAKE_OUT_EN];
			st_nxt.mon_dis     = SFR_REQ.wdata[BIT_MON_DISABLE];
		end

		st_nxt.stop = wr_power_control && SFR_REQ.wdata[BIT_STOP];
		st_nxt.idle = wr_power_control && SFR_REQ.wdata[BIT_IDLE];
		if (wr_power_control) begin
			st_nxt.gflags = SFR_REQ.wdata[GF_HI:GF_LO];
			st_nxt.supply = SFR_REQ.wdata[BIT_SUPPLY];
		end

		st_nxt.susp_go  = SUSPEND_REQ && !any_flag;
		st_nxt.sleep_go = SLEEP_REQ && !any_flag;
		st_nxt.osc_go   = LPOSC_OFF_REQ && !any_flag;

		st_nxt.rtc_o    = st_r.clk_out_en && rtc_s;
		st_nxt.rtc_oe_n = !st_r.clk_out_en;

		// The request pin idles high and pulses low after a sleep exit.
		// request pin enable
		if (SLEEP_EXIT && st_r.wake_out_en) begin
			st_nxt.wake_cnt = PULSE_LOAD;
		end else if (st_r.wake_cnt != '0) begin
			st_nxt.wake_cnt = st_r.wake_cnt - 1'b1;
		end
		st_nxt.wake_o    = !(st_r.wake_out_en && (st_nxt.wake_cnt != '0));
		st_nxt.wake_oe_n = !st_r.wake_out_en;

		// Read data is registered; unmapped addresses answer zero.
		// reserved read zero
		st_nxt.rdata = 8'h00;
		if (hit(SFR_REQ, ADDR_WAKE_MODE, 1'b1, PAGE_WAKE_FLAG)) begin
			st_nxt.rdata[BIT_BATT_WAKE]  = vis_flags.batt;
			st_nxt.rdata[BIT_PULSE_WAKE] = vis_flags.pulse;
		end else if (hit(SFR_REQ, ADDR_WAKE_MODE, 1'b1, PAGE_MODE)) begin
			st_nxt.rdata[BIT_CLK_OUT_EN]  = st_r.clk_out_en;
			st_nxt.rdata[BIT_WAKE_OUT_EN] = st_r.wake_out_en;
			st_nxt.rdata[BIT_MON_DISABLE] = st_r.mon_dis;
		end else if (hit(SFR_REQ, ADDR_POWER_CONTROL, 1'b0, 4'h0)) begin
			st_nxt.rdata[GF_HI:GF_LO] = st_r.gflags;
			st_nxt.rdata[BIT_SUPPLY]  = st_r.supply;
		end
	end

	// Reset also re-enables the supply monitor.
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r             <= '0;
			st_r.flags       <= RST_WAKE_FLAGS;
			st_r.clk_out_en  <= RST_MODE[BIT_CLK_OUT_EN];
			st_r.supply      <= RST_POWER_CONTROL[BIT_SUPPLY];
			st_r.rtc_oe_n    <= 1'b1;
			st_r.wake_o      <= 1'b1;
			st_r.wake_oe_n   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign SFR_RDATA       = st_r.rdata;
	assign SUSPEND_GO      = st_r.susp_go;
	assign SLEEP_GO        = st_r.sleep_go;
	assign LPOSC_OFF_GO    = st_r.osc_go;
	assign BATT_WAKE_EN    = st_r.enable.batt;
	assign PULSE_WAKE_EN   = st_r.enable.pulse;
	assign RTC_PIN_O       = st_r.rtc_o;
	assign RTC_PIN_OE_N    = st_r.rtc_oe_n;
	assign WAKE_PIN_O      = st_r.wake_o;
	assign WAKE_PIN_OE_N   = st_r.wake_oe_n;
	assign MONITOR_DISABLE = st_r.mon_dis;
	assign SUPPLY_SELECT   = st_r.supply;
	assign STOP_PULSE      = st_r.stop;
	assign IDLE_PULSE      = st_r.idle;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	logic wr_pc_a;
	logic wr_fl_a;
	logic rd_fl_a;
	logic rd_md_a;
	assign wr_pc_a = SFR_REQ.wr && (SFR_REQ.addr == ADDR_POWER_CONTROL);
	assign wr_fl_a = SFR_REQ.wr && (SFR_REQ.addr == ADDR_WAKE_MODE)
		&& (SFR_REQ.page == PAGE_WAKE_FLAG);
	assign rd_fl_a = (SFR_REQ.addr == ADDR_WAKE_MODE) && (SFR_REQ.page == PAGE_WAKE_FLAG);
	assign rd_md_a = (SFR_REQ.addr == ADDR_WAKE_MODE) && (SFR_REQ.page == PAGE_MODE);

	sequence s_blank_two;
		(vis_flags == '0) [*2];
	endsequence

	sequence s_low_pulse;
		!WAKE_PIN_O [*8];
	endsequence

	chk_refuse_sleep: assert property (SLEEP_REQ && (st_r.flags != '0) |=> !SLEEP_GO)
		else $error("sleep granted with a wake flag set");
	chk_refuse_suspend: assert property (
		(SUSPEND_REQ || LPOSC_OFF_REQ) && (st_r.flags != '0) |=> !SUSPEND_GO && !LPOSC_OFF_GO)
		else $error("suspend or oscillator off granted with a wake flag set");
	chk_suspend_blank: assert property (SUSPEND_WAKE |=> s_blank_two)
		else $error("wake flags visible inside suspend blanking");
	chk_event_sets_flag: assert property (evt.pulse || evt.batt |=> st_r.flags != '0)
		else $error("wake event did not set its flag");
	chk_batt_enable: assert property (
		wr_fl_a |=> BATT_WAKE_EN == $past(SFR_REQ.wdata[BIT_BATT_WAKE]))
		else $error("battery wake enable not stored");
	chk_flag_reserved: assert property (rd_fl_a |=> SFR_RDATA[7:3] == '0 && !SFR_RDATA[1])
		else $error("reserved flag bits read nonzero");
	chk_mode_low_zero: assert property (rd_md_a |=> SFR_RDATA[4:0] == '0)
		else $error("unused mode bits read nonzero");
	chk_clock_out_off: assert property (!st_r.clk_out_en |=> RTC_PIN_OE_N && !RTC_PIN_O)
		else $error("clock output driven while disabled");
	chk_wake_low_pulse: assert property (
		SLEEP_EXIT && st_r.wake_out_en |=> s_low_pulse)
		else $error("wake request not held low after sleep exit");
	chk_general_flags: assert property (
		wr_pc_a |=> st_r.gflags == $past(SFR_REQ.wdata[GF_HI:GF_LO])
			&& SUPPLY_SELECT == $past(SFR_REQ.wdata[BIT_SUPPLY]))
		else $error("power control write not stored");
	chk_stop_strobe: assert property (
		wr_pc_a && SFR_REQ.wdata[BIT_STOP] |=> STOP_PULSE ##1 (!STOP_PULSE || $past(wr_pc_a)))
		else $error("stop strobe not one cycle");

endmodule : power_unit_flags

// File: verilog/power_unit_pkg.sv
package power_unit_pkg;

	// Register addresses; the flag and mode registers share one address and
	// are told apart by the page selector.
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_WAKE_MODE     = 8'hb6;
	localparam logic [3:0] PAGE_WAKE_FLAG     = 4'h0;
	localparam logic [3:0] PAGE_MODE          = 4'hf;

	// Reset values.
	localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_MODE          = 8'h00;
	localparam logic [1:0] RST_WAKE_FLAGS    = 2'h0;

	// Field positions in the wake flag register.
	localparam int BIT_BATT_WAKE  = 2;
	localparam int BIT_PULSE_WAKE = 0;

	// Field positions in the mode register.
	localparam int BIT_CLK_OUT_EN  = 7;
	localparam int BIT_WAKE_OUT_EN = 6;
	localparam int BIT_MON_DISABLE = 5;

	// Field positions in the power control register.
	localparam int GF_HI      = 7;
	localparam int GF_LO      = 3;
	localparam int BIT_SUPPLY = 2;
	localparam int BIT_STOP   = 1;
	localparam int BIT_IDLE   = 0;

	// Timing.
	localparam int CLK_PERIOD_NS   = 10;
	localparam int WAKE_PULSE_NS   = 100;
	localparam int WAKE_PULSE_CYC  = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLAG_BLANK_CYC  = 2;
	localparam int SYNC_STAGES     = 2;

	// One special-function-register access from the core.
	typedef struct packed {
		logic [3:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
	} sfr_req_t;

	// The two wake sources of this register, battery monitor first.
	typedef struct packed {
		logic batt;
		logic pulse;
	} wake_pair_t;

endpackage : power_unit_pkg

// File: verilog/level_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for levels arriving from another clock domain.
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		st_nxt.meta   = D;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign Q = st_r.stable;

endmodule : level_sync

// File: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import power_unit_pkg::*;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	sfr_req_t   req = '0;
	logic       batt_ev = 1'b0, pulse_ev = 1'b0, clr = 1'b0, susp_wake = 1'b0;
	logic       slp_exit = 1'b0, susp_req = 1'b0, slp_req = 1'b0, osc_req = 1'b0;
	logic       rtc_osc = 1'b0;
	logic [7:0] rdata;
	logic       susp_go, slp_go, osc_go, batt_en, pulse_en, rtc_o, rtc_oe_n;
	logic       wake_o, wake_oe_n, mon_dis, sup_sel, stop_p, idle_p;
	logic [7:0] seed = 8'h3c;
	logic [7:0] d, got;
	int         fails = 0, checked = 0, fl_m = 0, cnt;
	int         exp_q[$];

	// The clock toggles every half period.
	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	power_unit_flags u_power_unit_flags (
		.CLK(clk), .RST(rst), .SFR_REQ(req), .SFR_RDATA(rdata),
		.BATT_MON_EVENT(batt_ev), .PULSE_COUNT_EVENT(pulse_ev), .FLAG_CLEAR(clr),
		.SUSPEND_WAKE(susp_wake), .SLEEP_EXIT(slp_exit), .SUSPEND_REQ(susp_req),
		.SLEEP_REQ(slp_req), .LPOSC_OFF_REQ(osc_req), .SUSPEND_GO(susp_go),
		.SLEEP_GO(slp_go), .LPOSC_OFF_GO(osc_go), .BATT_WAKE_EN(batt_en),
		.PULSE_WAKE_EN(pulse_en), .RTC_OSC(rtc_osc), .RTC_PIN_O(rtc_o),
		.RTC_PIN_OE_N(rtc_oe_n), .WAKE_PIN_O(wake_o), .WAKE_PIN_OE_N(wake_oe_n),
		.MONITOR_DISABLE(mon_dis), .SUPPLY_SELECT(sup_sel), .STOP_PULSE(stop_p),
		.IDLE_PULSE(idle_p)
	);

	// Eight-bit shift register sequence for the random register values.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic close_out();
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask : check

	// A write holds its strobe for exactly one rising edge.
	task automatic sfr_wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] wd);
		@(negedge clk);
		req = '{pg, a, wd, 1'b1};
		@(posedge clk);
		#1;
		check({6'h00, stop_p, idle_p}, {6'h00, wd[1:0] & {2{a == ADDR_POWER_CONTROL}}},
			"mode pulse");
		@(negedge clk);
		req.wr = 1'b0;
	endtask : sfr_wr

	task automatic sfr_rd(input logic [3:0] pg, input logic [7:0] a, output logic [7:0] rd);
		@(negedge clk);
		req = '{pg, a, 8'h00, 1'b0};
		@(posedge clk);
		#1;
		rd = rdata;
	endtask : sfr_rd

	// All three low-power requests are raised together for one edge.
	task automatic go_check(input logic e);
		@(negedge clk);
		{susp_req, slp_req, osc_req} = 3'b111;
		@(posedge clk);
		#1;
		check({5'h00, susp_go, slp_go, osc_go}, {5'h00, {3{e}}}, "low power go");
		@(negedge clk);
		{susp_req, slp_req, osc_req} = 3'b000;
	endtask : go_check

	// Events cross two synchroniser stages, so five cycles is a safe settle time.
	task automatic fire(input logic b, input logic p, input logic c);
		@(negedge clk);
		{batt_ev, pulse_ev, clr} = {b, p, c};
		@(negedge clk);
		{batt_ev, pulse_ev, clr} = 3'b000;
		repeat (5) @(negedge clk);
		fl_m = c ? 0 : (fl_m | (b ? 4 : 0) | (p ? 1 : 0));
		sfr_rd(PAGE_WAKE_FLAG, ADDR_WAKE_MODE, got);
		check(got, 8'(fl_m), "wake flags");
	endtask : fire

	// Counts the cycles the wake request pin spends low after one sleep exit.
	task automatic wake_count(input int e);
		@(negedge clk);
		slp_exit = 1'b1;
		@(negedge clk);
		slp_exit = 1'b0;
		cnt = 0;
		// The pin falls at the edge that takes the exit, so sample before waiting.
		repeat (WAKE_PULSE_CYC + 10) begin
			if (wake_o === 1'b0)
				cnt++;
			@(negedge clk);
		end
		check(8'(cnt), 8'(e), "wake request width");
	endtask : wake_count

	// Watchdog sized well past the few hundred cycles the sequence needs.
	initial begin
		#200000;
		fails++;
		close_out();
	end

	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check({rtc_oe_n, wake_o, wake_oe_n, mon_dis, sup_sel, batt_en, pulse_en, susp_go},
			8'he0, "reset outputs");
		sfr_rd(PAGE_MODE, ADDR_WAKE_MODE, got);
		check(got, RST_MODE, "mode reset");
		sfr_rd(4'h3, ADDR_POWER_CONTROL, got);
		check(got, RST_POWER_CONTROL, "control reset");
		// Software clears the wake sources after reset.
		fire(1'b0, 1'b0, 1'b1);
		// Boundary values first, then random ones, through all three registers.
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed;
			seed = lfsr(seed);
			sfr_wr(4'h0, ADDR_POWER_CONTROL, d);
			check({7'h00, sup_sel}, {7'h00, d[2]}, "supply select");
			sfr_rd(4'h5, ADDR_POWER_CONTROL, got);
			check(got, d & 8'hfc, "control readback");
			sfr_wr(PAGE_MODE, ADDR_WAKE_MODE, d);
			// The pin enable follows the stored bit one cycle later.
			@(negedge clk);
			check({6'h00, rtc_oe_n, mon_dis}, {6'h00, ~d[7], d[5]}, "mode out");
			sfr_rd(PAGE_MODE, ADDR_WAKE_MODE, got);
			check(got, d & 8'he0, "mode readback");
			sfr_wr(PAGE_WAKE_FLAG, ADDR_WAKE_MODE, d & 8'hfd);
			check({6'h00, batt_en, pulse_en}, {6'h00, d[2], d[0]}, "wake enables");
			sfr_rd(PAGE_WAKE_FLAG, ADDR_WAKE_MODE, got);
			check(got, 8'h00, "idle flags");
			sfr_rd(4'h7, 8'h55, got);
			check(got, 8'h00, "unmapped read");
		end
		// The buffered oscillator follows the input while enabled.
		cnt = 0;
		repeat (12) begin
			@(negedge clk);
			rtc_osc = ~rtc_osc;
			if (rtc_o !== got[0])
				cnt++;
			got[0] = rtc_o;
		end
		check({7'h00, cnt > 4}, {7'h00, d[7]}, "clock out toggles");
		sfr_wr(PAGE_WAKE_FLAG, ADDR_WAKE_MODE, 8'h00);
		fire(1'b1, 1'b0, 1'b0);
		go_check(1'b0);
		// Flags read zero for two clocks after a suspend wake, then return.
		// The read taken in the wake cycle itself still shows the old flags.
		exp_q = '{fl_m, 0, 0, fl_m};
		@(negedge clk);
		req = '{PAGE_WAKE_FLAG, ADDR_WAKE_MODE, 8'h00, 1'b0};
		susp_wake = 1'b1;
		foreach (exp_q[k]) begin
			@(posedge clk);
			#1;
			check(rdata, 8'(exp_q[k]), "suspend blank");
			@(negedge clk);
			susp_wake = 1'b0;
		end
		fire(1'b0, 1'b0, 1'b1);
		go_check(1'b1);
		fire(1'b0, 1'b1, 1'b0);
		go_check(1'b0);
		fire(1'b1, 1'b1, 1'b0);
		fire(1'b0, 1'b0, 1'b1);
		sfr_wr(PAGE_MODE, ADDR_WAKE_MODE, 8'h40);
		@(negedge clk);
		check({7'h00, wake_oe_n}, 8'h00, "wake pin driven");
		wake_count(WAKE_PULSE_CYC);
		sfr_wr(PAGE_MODE, ADDR_WAKE_MODE, 8'h00);
		@(negedge clk);
		check({7'h00, wake_oe_n}, 8'h01, "wake pin released");
		wake_count(0);
		close_out();
	end

endmodule : tb_top
